// [tk_pkg.sv]
// Purpose: shared constants, types and crc helpers for the touch key
//          host command interpreter
// Assumes: 20 MHz system clock, one byte per command strobe
// Notes:   crc algorithms are fixed here and must match the host
//------------------------------------------------------------------
// package
//------------------------------------------------------------------
package tk_pkg;

  // timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int TIMEOUT_MS  = 100;
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int TMR_W       = 22;

  // command codes
  localparam logic [7:0] CMD_NULL    = 8'h00;
  localparam logic [7:0] CMD_SETUPS  = 8'h01;
  localparam logic [7:0] CMD_RECAL   = 8'h03;
  localparam logic [7:0] CMD_RESET   = 8'h04;
  localparam logic [7:0] CMD_STATUS  = 8'h05;
  localparam logic [7:0] CMD_FIRST   = 8'h06;
  localparam logic [7:0] CMD_ALLKEYS = 8'h07;
  localparam logic [7:0] CMD_SIGNALS = 8'h08;
  localparam logic [7:0] CMD_LAST    = 8'h0f;

  // fixed replies
  localparam logic [7:0] REPLY_READY = 8'hfe;
  localparam logic [7:0] REPLY_NAK   = 8'h00;

  // setups block and report sizes
  localparam logic [7:0] SETUPS_BLOCK_LENGTH = 8'h40;
  localparam logic [6:0] LEN_ONE     = 7'h01;
  localparam logic [6:0] LEN_KEYS    = 7'h06;
  localparam logic [6:0] LEN_SIGNALS = 7'h60;
  localparam int         NUM_KEYS    = 48;
  localparam logic [5:0] NO_KEY      = 6'h3f;

  // crc algorithms
  localparam logic [7:0]  CRC8_POLY  = 8'h07;
  localparam logic [7:0]  CRC8_INIT  = 8'h00;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'h0000;

  // general status and first-key bit positions
  localparam int ST_COMM   = 6;
  localparam int ST_FMEA   = 5;
  localparam int ST_STORE  = 4;
  localparam int ST_SYNC   = 3;
  localparam int ST_KEYERR = 2;
  localparam int ST_CAL    = 1;
  localparam int ST_DET    = 0;
  localparam int FK_MULTI  = 7;
  localparam int FK_ERR    = 6;

  // sensing condition flags from the analog side
  typedef struct packed {
    logic fmea_fail;
    logic store_corrupt;
    logic sync_fail;
    logic cal_fail5;
    logic low_ref;
    logic any_cal;
  } key_flags_t;

  // one nonvolatile byte write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } nvm_wr_t;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_ARMED = 6'b000010,
    S_EMIT  = 6'b000100,
    S_LOAD  = 6'b001000,
    S_BURN  = 6'b010000,
    S_FINAL = 6'b100000
  } state_t;

  function automatic logic [7:0] crc8_upd(input logic [7:0] c,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = {r[6:0], 1'b0} ^ (r[7] ? CRC8_POLY : 8'h00);
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16_upd(input logic [15:0] c,
                                             input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = {r[14:0], 1'b0} ^ (r[15] ? CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction

endpackage

// [resp_buffer.sv]
// Purpose: two-entry response byte buffer with valid/ready both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   full drops in_ready so the producer stalls, nothing is lost
`timescale 1ns/1ps
`default_nettype none
module resp_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  // handshake terms
  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage and pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // data array needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
    count <= 2'd2) else $error("response buffer overflow");

endmodule // resp_buffer
`default_nettype wire

// [touch_key_host_command_set.sv]
// Purpose: decode host command bytes and build response byte streams
// Assumes: framing layer hands over one byte per cmd_valid strobe on clk
// Notes:   spi_mode gates each response byte on one null command
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------------
// command interpreter
//------------------------------------------------------------------
// Function
// [R1] SPI: one null command fetches one byte
// [R2] setups entry halts sensing, accepts block
// [R3] setups, recal, reset need double issue
// [R4] missing second copy: abandon silently
// [R5] 0xFE when ready, 0xFE after store
// [R6] load byte gap over 100ms aborts
// [R7] host sends CRC-16, low byte first
// [R8] bad CRC answers 0x00 not 0xFE
// [R9] received CRC zero skips comparison
// [R10] always store; bad CRC marks storage invalid
// [R11] sensing restarts after load; host resets
// [R12] recalibrate all, answer 0xFC
// [R13] forced reset answers 0xFB first
// [R14] status bits 6,5,4: comm, fault, storage
// [R15] status bits 3..0: sync, key, cal, detect
// [R16] comm error held until last-command request
// [R17] status/first/all reports end with CRC-8
// [R18] first-key bit 7: two or more touches
// [R19] first-key bit 6: any error condition; the code leaves low_ref out of it
// [R20] first-key low bits: key or 0x3F
// [R21] all-keys: six bytes plus CRC-8
// [R22] signals: 96 bytes, low first, no CRC
// [R23] last-command returns inverse, clears comm error
// [R24] host reissues on bad or missing reply
// [R25] CRC algorithms fixed as shared constants
module touch_key_host_command_set
  import tk_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          spi_mode,
  input  wire logic          cmd_valid,
  input  wire logic [7:0]    cmd_byte,
  output logic               resp_valid,
  output logic [7:0]         resp_data,
  input  wire logic          resp_ready,
  input  wire logic [47:0]   key_detect,
  input  wire key_flags_t    key_flags,
  output logic [5:0]         sig_index,
  input  wire logic [15:0]   sig_level,
  output logic               sensing_halt,
  output logic               recal_start,
  output logic               reset_request,
  output logic               nvm_we,
  output nvm_wr_t            nvm_wr,
  output logic               nvm_commit,
  output logic               nvm_valid,
  input  wire logic          nvm_done,
  output logic               comm_err
);

  state_t            state;
  state_t            after_state;
  logic [7:0]        cur_cmd;
  logic [7:0]        reply_byte;
  logic [7:0]        last_cmd;
  logic [7:0]        idx;
  logic [6:0]        emit_len;
  logic              has_crc;
  logic [7:0]        crc8;
  logic [15:0]       crc16;
  logic [7:0]        rx_lo;
  logic              crc_ok;
  logic [TMR_W-1:0]  tmr;
  logic [6:0]        credit;
  logic              push_valid;
  logic [7:0]        push_data;
  logic [7:0]        emit_data;
  logic              buf_ready;
  logic              buf_valid;
  logic [7:0]        buf_data;
  logic              take;
  logic              last_byte;
  logic              cmd_phase;
  logic              known;
  logic [7:0]        status_byte;
  logic [7:0]        first_byte;

  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(TIMEOUT_CYCLES - 1);

  // lowest numbered touched key, or the no-key code
  function automatic logic [5:0] first_key(input logic [47:0] kd);
    logic [5:0] k;
    k = NO_KEY;
    for (int i = NUM_KEYS - 1; i >= 0; i--) begin
      if (kd[i]) begin
        k = 6'(i);
      end
    end
    return k;
  endfunction

  // report bytes built from live sensing state
  always_comb begin
    status_byte           = 8'h00;
    status_byte[ST_COMM]  = comm_err;                      // see [R14]
    status_byte[ST_FMEA]  = key_flags.fmea_fail;           // see [R14]
    status_byte[ST_STORE] = key_flags.store_corrupt;       // see [R14]
    status_byte[ST_SYNC]  = key_flags.sync_fail;           // see [R15]
    status_byte[ST_KEYERR] = key_flags.cal_fail5 | key_flags.low_ref;
    status_byte[ST_CAL]   = key_flags.any_cal;             // see [R15]
    status_byte[ST_DET]   = |key_detect;                   // see [R15]
    first_byte[5:0]       = first_key(key_detect);         // see [R20]
    first_byte[FK_MULTI]  = |(key_detect & (key_detect - 48'h1)); // see [R18]
    first_byte[FK_ERR]    = key_flags.any_cal | key_flags.cal_fail5 |
                            key_flags.sync_fail | comm_err |
                            key_flags.fmea_fail | key_flags.store_corrupt;
  end                                                      // see [R19]

  // data byte for the current position of the reply stream
  always_comb begin
    unique case (cur_cmd)
      CMD_STATUS:  emit_data = status_byte;
      CMD_FIRST:   emit_data = first_byte;
      CMD_ALLKEYS: emit_data = key_detect[idx[2:0]*8 +: 8];  // see [R21]
      CMD_SIGNALS: emit_data = idx[0] ? sig_level[15:8]
                                      : sig_level[7:0];      // see [R22]
      default:     emit_data = reply_byte;
    endcase
  end

  // stream control terms
  assign cmd_phase  = (state == S_IDLE) || (state == S_ARMED);
  assign take       = cmd_valid && cmd_phase && (cmd_byte != CMD_NULL);
  assign push_valid = (state == S_EMIT);
  assign last_byte  = ({1'b0, idx} == ({2'b00, emit_len} + {8'h00, has_crc}
                      - 9'h1));
  // trailing checksum after the data bytes
  assign push_data  = (has_crc && idx == {1'b0, emit_len}) ? crc8
                                                           : emit_data;
  assign known      = (cmd_byte == CMD_SETUPS) || (cmd_byte == CMD_RECAL) ||
                      (cmd_byte == CMD_RESET) || (cmd_byte == CMD_STATUS) ||
                      (cmd_byte == CMD_FIRST) || (cmd_byte == CMD_ALLKEYS) ||
                      (cmd_byte == CMD_SIGNALS) || (cmd_byte == CMD_LAST);

  resp_buffer #(.WIDTH(8)) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (buf_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready ((!resp_valid || resp_ready) &&
                (!spi_mode || credit != 7'h00))
  );

  // main sequencer: decode, double issue, emit, load, store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= S_IDLE;
      after_state   <= S_IDLE;
      cur_cmd       <= CMD_NULL;
      reply_byte    <= 8'h00;
      idx           <= 8'h00;
      emit_len      <= 7'h00;
      has_crc       <= 1'b0;
      crc8          <= CRC8_INIT;
      crc16         <= CRC16_INIT;
      rx_lo         <= 8'h00;
      crc_ok        <= 1'b0;
      tmr           <= '0;
      sig_index     <= 6'h00;
      sensing_halt  <= 1'b0;
      recal_start   <= 1'b0;
      reset_request <= 1'b0;
      nvm_we        <= 1'b0;
      nvm_wr        <= '0;
      nvm_commit    <= 1'b0;
      nvm_valid     <= 1'b0;
    end else begin
      recal_start <= 1'b0;
      nvm_we      <= 1'b0;
      nvm_commit  <= 1'b0;
      idx         <= (state == S_EMIT || state == S_LOAD) ? idx : 8'h00;
      sig_index   <= (state == S_EMIT) ? sig_index : 6'h00;
      unique case (state)
        S_IDLE, S_ARMED: begin
          if (take && state == S_ARMED && cmd_byte == cur_cmd) begin
            // second copy arrived in time: execute
            state    <= S_EMIT;                            // see [R3]
            emit_len <= LEN_ONE;
            has_crc  <= 1'b0;
            if (cur_cmd == CMD_SETUPS) begin
              sensing_halt <= 1'b1;                        // see [R2]
              reply_byte   <= REPLY_READY;                 // see [R5]
              after_state  <= S_LOAD;
              crc16        <= CRC16_INIT;
            end else if (cur_cmd == CMD_RECAL) begin
              recal_start <= 1'b1;                         // see [R12]
              reply_byte  <= ~CMD_RECAL;                   // see [R12]
              after_state <= S_IDLE;
            end else begin
              reply_byte  <= ~CMD_RESET;                   // see [R13]
              after_state <= S_FINAL;
            end
          end else if (take) begin
            // fresh command; an unequal byte abandons an armed one
            cur_cmd     <= cmd_byte;
            crc8        <= crc8_upd(CRC8_INIT, cmd_byte);  // see [R17]
            after_state <= S_IDLE;
            has_crc     <= 1'b1;
            emit_len    <= LEN_ONE;
            state       <= S_EMIT;
            unique case (cmd_byte)
              CMD_SETUPS, CMD_RECAL, CMD_RESET: begin
                state <= S_ARMED;                          // see [R3]
                tmr   <= TMR_LOAD;
              end
              CMD_ALLKEYS: emit_len <= LEN_KEYS;           // see [R21]
              CMD_SIGNALS: begin
                emit_len <= LEN_SIGNALS;                   // see [R22]
                has_crc  <= 1'b0;
              end
              CMD_LAST: begin
                reply_byte <= ~last_cmd;                   // see [R23]
                has_crc    <= 1'b0;
              end
              CMD_STATUS, CMD_FIRST: emit_len <= LEN_ONE;  // see [R17]
              default: state <= S_IDLE;
            endcase
          end else if (state == S_ARMED) begin
            if (tmr == '0) begin
              state <= S_IDLE;                             // see [R4]
            end else begin
              tmr <= tmr - 1'b1;
            end
          end
        end
        S_EMIT: begin
          if (buf_ready) begin
            crc8      <= crc8_upd(crc8, emit_data);        // see [R17]
            idx       <= idx + 8'h01;
            sig_index <= 6'((idx + 8'h01) >> 1);           // see [R22]
            if (last_byte) begin
              state <= after_state;
              idx   <= 8'h00;
              tmr   <= TMR_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (cmd_valid) begin
            tmr <= TMR_LOAD;                               // see [R6]
            idx <= idx + 8'h01;
            if (idx < SETUPS_BLOCK_LENGTH) begin
              nvm_we <= 1'b1;                              // see [R2]
              nvm_wr <= '{addr: idx, data: cmd_byte};
              crc16  <= crc16_upd(crc16, cmd_byte);        // see [R25]
            end else if (idx == SETUPS_BLOCK_LENGTH) begin
              rx_lo <= cmd_byte;                           // see [R7]
            end else begin
              // zero checksum is always accepted
              crc_ok <= ({cmd_byte, rx_lo} == 16'h0000) ||
                        ({cmd_byte, rx_lo} == crc16);      // see [R9]
              nvm_valid <= ({cmd_byte, rx_lo} == 16'h0000) ||
                           ({cmd_byte, rx_lo} == crc16);   // see [R10]
              nvm_commit <= 1'b1;                          // see [R10]
              state      <= S_BURN;
            end
          end else if (tmr == '0) begin
            state        <= S_IDLE;                        // see [R6]
            sensing_halt <= 1'b0;
          end else begin
            tmr <= tmr - 1'b1;
          end
        end
        S_BURN: begin
          if (nvm_done) begin
            reply_byte   <= crc_ok ? REPLY_READY : REPLY_NAK; // see [R8]
            sensing_halt <= 1'b0;                          // see [R11]
            cur_cmd      <= CMD_SETUPS;
            emit_len     <= LEN_ONE;
            has_crc      <= 1'b0;
            after_state  <= S_IDLE;
            state        <= S_EMIT;                        // see [R5]
          end
        end
        S_FINAL: begin
          // reset only once the acknowledge has left the device
          if (!buf_valid && !resp_valid) begin
            reset_request <= 1'b1;                         // see [R13]
          end
        end
      endcase
    end
  end

  // last command byte, kept for the inverse echo
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_cmd <= CMD_NULL;
    end else if (take) begin
      last_cmd <= cmd_byte;                                // see [R23]
    end
  end

  // communications error: set wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_err <= 1'b0;
    end else if ((take && !known) ||
                 (cmd_valid && cmd_byte != CMD_NULL &&
                  (state == S_EMIT || state == S_BURN))) begin
      comm_err <= 1'b1;                                    // see [R16]
    end else if (take && cmd_byte == CMD_LAST) begin
      comm_err <= 1'b0;                                    // see [R23]
    end
  end

  // fetch credits: one null command releases one byte in spi mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      credit <= 7'h00;
    end else begin
      credit <= credit
        + {6'h00, (spi_mode && cmd_valid && cmd_byte == CMD_NULL &&
                   state != S_LOAD && credit != 7'h7f)}     // see [R1]
        - {6'h00, (spi_mode && buf_valid && credit != 7'h00 &&
                   (!resp_valid || resp_ready))};
    end
  end

  // registered response output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_data  <= 8'h00;
    end else if (!resp_valid || resp_ready) begin
      resp_valid <= buf_valid && (!spi_mode || credit != 7'h00); // see [R1]
      resp_data  <= buf_data;
    end
  end

  //------------------------------------------------------------------
  // assertions
  //------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  null_fetch_a: assert property (                          // see [R1]
    $rose(resp_valid) && spi_mode |-> $past(credit) != 7'h00)
    else $error("spi byte released without a null fetch");
  double_issue_a: assert property (                        // see [R3]
    state == S_ARMED && take && cmd_byte == cur_cmd && cur_cmd == CMD_RECAL
    |=> recal_start && reply_byte == 8'hfc)
    else $error("recalibrate not executed on second copy");
  armed_expire_a: assert property (                        // see [R4]
    state == S_ARMED && tmr == '0 && !take |=> state == S_IDLE ##1 !push_valid)
    else $error("armed command not abandoned on timeout");
  load_ready_a: assert property (                          // see [R5]
    state == S_ARMED && take && cmd_byte == cur_cmd && cur_cmd == CMD_SETUPS
    |=> sensing_halt && push_valid && push_data == REPLY_READY)
    else $error("setups entry did not send ready byte");
  load_gap_a: assert property (                            // see [R6]
    state == S_LOAD && tmr == '0 && !cmd_valid
    |=> state == S_IDLE && !sensing_halt)
    else $error("load gap timeout not taken");
  crc_nak_a: assert property (                             // see [R8]
    state == S_BURN && nvm_done && !crc_ok |=> push_data == REPLY_NAK)
    else $error("bad checksum not answered with nak");
  crc_zero_a: assert property (                            // see [R9]
    state == S_LOAD && cmd_valid && idx == SETUPS_BLOCK_LENGTH + 8'h01 &&
    cmd_byte == 8'h00 && rx_lo == 8'h00 |=> crc_ok && nvm_commit)
    else $error("zero checksum rejected");
  store_mark_a: assert property (                          // see [R10]
    nvm_commit |-> nvm_valid == crc_ok && state == S_BURN)
    else $error("storage validity mark wrong");
  reset_ack_a: assert property (                           // see [R13]
    $rose(reset_request) |-> $past(state) == S_FINAL && !resp_valid)
    else $error("reset before acknowledge left");
  comm_clear_a: assert property (                          // see [R16]
    take && cmd_byte == CMD_LAST |=> !comm_err)
    else $error("comm error not cleared");
  no_key_a: assert property (                              // see [R20]
    state == S_EMIT && cur_cmd == CMD_FIRST && idx == 8'h00 && key_detect == '0
    |-> push_data[5:0] == NO_KEY && !push_data[FK_MULTI])
    else $error("first key report wrong with no touch");

  load_done_c: cover property (state == S_BURN ##[1:20] state == S_EMIT);
  recal_c:     cover property (recal_start);
  signals_c:   cover property (state == S_EMIT && cur_cmd == CMD_SIGNALS
                               && last_byte && buf_ready);
  expire_c:    cover property (state == S_ARMED && tmr == '0);

endmodule // touch_key_host_command_set
`default_nettype wire

// [tk_far_side.sv]
// Purpose: storage and signal source beside the interpreter
// Assumes: one clock, asynchronous active-low reset
// Notes:   a commit finishes two cycles after it is requested
`timescale 1ns/1ps
`default_nettype none
module tk_far_side (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  sig_index,
  output logic      [15:0] sig_level,
  input  wire logic        nvm_commit,
  output logic             nvm_done
);
  logic [1:0] busy;
  // key number in both bytes, high byte marked by bit 6
  assign sig_level = {2'h1, sig_index, 2'h0, sig_index};
  // store delay line ends in the done pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy <= 2'h0;
    else busy <= {busy[0], nvm_commit};
  end
  assign nvm_done = busy[1];
endmodule // tk_far_side
`default_nettype wire

// [touch_key_host_command_set_bench.sv]
// Purpose: self-checking bench for the host command interpreter
// Assumes: uart then spi fetch mode, arming timeout of 50 cycles
// Notes:   replies are taken one byte at a time, stalling the buffer
`timescale 1ns/1ps
`default_nettype none
module touch_key_host_command_set_bench;
  import tk_pkg::*;
  logic        clk, rst_n, cmd_valid, resp_valid, resp_ready;
  logic [7:0]  cmd_byte, resp_data, c;
  logic [47:0] key_detect;
  key_flags_t  key_flags;
  logic [5:0]  sig_index;
  logic [15:0] sig_level;
  logic        recal_start, comm_err, nvm_commit, nvm_done;
  logic        spi, reset_request, nvm_valid;
  int          n_fail, total_checks, cyc, n_recal;
  //----------------------------------------------
  // design and far side
  //----------------------------------------------
  touch_key_host_command_set #(.TIMEOUT_CYCLES(50)) DUT (.clk(clk),
    .rst_n(rst_n), .spi_mode(spi), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_ready(resp_ready), .key_detect(key_detect),
    .key_flags(key_flags), .sig_index(sig_index), .sig_level(sig_level),
    .sensing_halt(), .recal_start(recal_start), .reset_request(reset_request),
    .nvm_we(), .nvm_wr(), .nvm_commit(nvm_commit), .nvm_valid(nvm_valid),
    .nvm_done(nvm_done), .comm_err(comm_err));
  tk_far_side far (.clk(clk), .rst_n(rst_n), .sig_index(sig_index),
    .sig_level(sig_level), .nvm_commit(nvm_commit), .nvm_done(nvm_done));
  //----------------------------------------------
  // helpers
  //----------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cycle count, hang cut-off, recal pulse count
  always @(posedge clk) begin
    cyc++;
    if (recal_start === 1'b1) n_recal++;
    if (cyc > 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [7:0] crc8(logic [7:0] r, logic [7:0] d);
    r = r ^ d;
    for (int i = 0; i < 8; i++)
      r = {r[6:0], 1'b0} ^ (r[7] ? CRC8_POLY : 8'h00);
    return r;
  endfunction
  task automatic check(string name, logic [7:0] exp, logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(logic [7:0] b);
    @(posedge clk) #1 cmd_valid = 1'b1;
    cmd_byte = b;
    @(posedge clk) #1 cmd_valid = 1'b0;
  endtask
  // wait bounded for a reply byte, compare, then take it
  task automatic take(string name, logic [7:0] exp);
    if (spi) send(CMD_NULL);
    for (int i = 0; i < 40 && resp_valid !== 1'b1; i++) @(posedge clk) #1;
    check(name, exp, resp_valid === 1'b1 ? resp_data : ~exp);
    resp_ready = 1'b1;
    @(posedge clk) #1 resp_ready = 1'b0;
  endtask
  task automatic quiet(string name);
    repeat (20) @(posedge clk) #1 check(name, 8'h00, {7'h0, resp_valid});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  //----------------------------------------------
  // scenarios
  //----------------------------------------------
  task automatic t_status();
    send(CMD_STATUS);
    take("status", 8'h09);
    take("status crc", crc8(crc8(8'h00, CMD_STATUS), 8'h09));
    send(CMD_FIRST);
    take("first key", 8'hc2);
    take("first crc", crc8(crc8(8'h00, CMD_FIRST), 8'hc2));
    $display("status test done");
  endtask
  task automatic t_allkeys();
    c = crc8(8'h00, CMD_ALLKEYS);
    send(CMD_ALLKEYS);
    for (int k = 0; k < 6; k++) begin
      take("key bits", key_detect[8*k+:8]);
      c = crc8(c, key_detect[8*k+:8]);
    end
    take("keys crc", c);
    $display("all keys test done");
  endtask
  task automatic t_last();
    send(CMD_LAST);
    take("last", ~CMD_ALLKEYS);
    send(8'h33);
    quiet("unknown reply");
    check("comm set", 8'h01, {7'h0, comm_err});
    send(CMD_LAST);
    take("last bad", 8'hcc);
    check("comm clear", 8'h00, {7'h0, comm_err});
    $display("last command test done");
  endtask
  task automatic t_recal();
    send(CMD_RECAL);
    repeat (60) @(posedge clk) #1;
    send(CMD_RECAL);
    quiet("late copy");
    send(CMD_RECAL);
    take("recal ack", 8'hfc);
    check("recal pulses", 8'h01, n_recal[7:0]);
    $display("recal test done");
  endtask
  // double-issued entry, data bytes d&k, then the crc word
  task automatic load(logic [7:0] d, logic [15:0] crc);
    repeat (2) send(CMD_SETUPS);
    take("ready", REPLY_READY);
    for (int k = 0; k < 64; k++) send(d & k[7:0]);
    send(crc[7:0]);
    send(crc[15:8]);
  endtask
  task automatic t_setups();
    load(8'hff, 16'h0000);
    take("zero crc", REPLY_READY);
    check("valid", 8'h01, {7'h0, nvm_valid});
    load(8'h00, 16'h3412);
    take("bad crc", REPLY_NAK);
    check("invalid", 8'h00, {7'h0, nvm_valid});
    repeat (2) send(CMD_SETUPS);
    take("gap ready", REPLY_READY);
    repeat (60) @(posedge clk) #1;
    send(CMD_LAST);
    take("gap abort", ~CMD_SETUPS);
    $display("setups test done");
  endtask
  task automatic t_signals();
    send(CMD_SIGNALS);
    for (int k = 0; k < 48; k++) begin
      take("signal low", {2'h0, k[5:0]});
      take("signal high", {2'h1, k[5:0]});
    end
    quiet("signal tail");
    $display("signals test done");
  endtask
  task automatic t_spi();
    spi = 1'b1;
    send(CMD_LAST);
    quiet("no fetch");
    take("spi last", ~CMD_SIGNALS);
    t_status();
    spi = 1'b0;
    $display("spi test done");
  endtask
  task automatic t_reset();
    repeat (2) send(CMD_RESET);
    take("reset ack", ~CMD_RESET);
    repeat (2) @(posedge clk) #1;
    check("reset req", 8'h01, {7'h0, reset_request});
    $display("reset test done");
  endtask
  initial begin
    {spi, cmd_valid, resp_ready, cmd_byte, n_fail, total_checks, cyc} = '0;
    n_recal = 0;
    rst_n = 1'b0;
    key_detect = 48'h8000_0001_0104;
    key_flags = 6'b001000;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_status();
    t_allkeys();
    t_last();
    t_recal();
    t_setups();
    t_signals();
    t_spi();
    t_reset();
    print_verdict();
  end
endmodule // touch_key_host_command_set_bench
`default_nettype wire
